// ---- src/qsd_top.sv ----
// module: quad low-side switch protection and fault store
`timescale 1ns/100ps
`default_nettype none
module qsd_top #(
	parameter int OC_CYCLES   = qsd_pkg::OC_FILTER_CYCLES,
	parameter int GND_CYCLES  = qsd_pkg::GND_FILTER_CYCLES,
	parameter int OPEN_CYCLES = qsd_pkg::OPEN_FILTER_CYCLES
) (
	input  wire logic                   i_clk,
	input  wire logic                   i_reset_n,
	input  wire logic [qsd_pkg::NCH-1:0] i_ctrl_on,
	input  wire logic [qsd_pkg::NCH-1:0] i_overcurrent,
	input  wire logic [qsd_pkg::NCH-1:0] i_overtemp,
	input  wire logic [qsd_pkg::NCH-1:0] i_drain_low,
	input  wire logic [qsd_pkg::NCH-1:0] i_current_low,
	input  wire logic                   i_external_reset_n,
	input  wire logic                   i_undervoltage,
	input  wire logic                   i_spi_clk,
	input  wire logic                   i_chip_select_n,
	input  wire logic                   i_sdi,
	output logic [qsd_pkg::NCH-1:0]     o_channel_on,
	output logic                        o_sdo,
	output logic                        o_sdo_oe
);

	localparam int NCH = qsd_pkg::NCH;
	localparam int CW  = qsd_pkg::CNT_W;

	// ==========================================================
	// elaboration checks
	if (OC_CYCLES < 1 || OC_CYCLES >= 2 ** CW) begin : g_chk_oc
		$error("overcurrent filter count out of range");
	end
	if (GND_CYCLES < 1 || GND_CYCLES >= 2 ** CW) begin : g_chk_gnd
		$error("ground filter count out of range");
	end
	if (OPEN_CYCLES < 1 || OPEN_CYCLES >= 2 ** CW) begin : g_chk_open
		$error("open load filter count out of range");
	end

	// ==========================================================
	// helpers
	function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
		sat_inc = (&v) ? v : v + {{(CW-1){1'b0}}, 1'b1};
	endfunction

	function automatic logic [1:0] code_max(input logic [1:0] a, input logic [1:0] b);
		code_max = (a > b) ? a : b;
	endfunction

	// ==========================================================
	// pin synchronisers
	logic [qsd_pkg::SYN_W-1:0] pins;
	logic [qsd_pkg::SYN_W-1:0] meta_q;
	logic [qsd_pkg::SYN_W-1:0] sync_q;
	qsd_link_if                lnk ();

	assign pins = {lnk.first_seen, i_chip_select_n, i_undervoltage, i_external_reset_n,
		i_current_low, i_drain_low, i_overtemp, i_overcurrent, i_ctrl_on};

	// two-stage capture of every input except i_reset_n, i_spi_clk and i_sdi
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= pins;
			sync_q <= meta_q;
		end
	end

	logic [NCH-1:0] ctrl;
	logic [NCH-1:0] oc;
	logic [NCH-1:0] ot;
	logic [NCH-1:0] drain_low;
	logic [NCH-1:0] cur_low;
	logic           cs_n_s;
	logic           first_s;

	assign ctrl      = sync_q[qsd_pkg::SYN_CTRL  +: NCH];
	assign oc        = sync_q[qsd_pkg::SYN_OC    +: NCH];
	assign ot        = sync_q[qsd_pkg::SYN_OT    +: NCH];
	assign drain_low = sync_q[qsd_pkg::SYN_DRAIN +: NCH];
	assign cur_low   = sync_q[qsd_pkg::SYN_CUR   +: NCH];
	assign cs_n_s    = sync_q[qsd_pkg::SYN_CS];
	assign first_s   = sync_q[qsd_pkg::SYN_FIRST];

	// ==========================================================
	// channel state
	logic [NCH-1:0]          ctrl_prev_q, ctrl_prev_d;
	logic [NCH-1:0]          latch_q, latch_d;
	logic [NCH-1:0]          pend_q, pend_d;
	logic [NCH-1:0]          on_q, on_d;
	logic [NCH-1:0][CW-1:0]  oc_cnt_q, oc_cnt_d;
	logic [NCH-1:0][CW-1:0]  diag_cnt_q, diag_cnt_d;
	logic [NCH-1:0][1:0]     fail_q, fail_d;
	logic [NCH-1:0][1:0]     snap_q, snap_d;
	logic                    hold_q, hold_d;
	logic                    cs_prev_q, first_prev_q;
	logic                    cs_fall, clear_evt;
	logic [NCH-1:0]          live, trip, gnd_cond, open_cond, gnd_hit, open_hit;
	logic [NCH-1:0]          rise, ol_store;
	logic [NCH-1:0][1:0]     new_code, base_code;

	// reset pin or undervoltage holds the block
	assign hold_d    = !sync_q[qsd_pkg::SYN_EXTRST] || sync_q[qsd_pkg::SYN_UV];
	assign cs_fall   = cs_prev_q && !cs_n_s;
	assign clear_evt = first_s && !first_prev_q;

	// next state of every channel
	always_comb begin
		ctrl_prev_d = ctrl;
		for (int i = 0; i < NCH; i++) begin
			rise[i]  = ctrl[i] && !ctrl_prev_q[i];
			live[i]  = on_q[i];
			oc_cnt_d[i] = (live[i] && oc[i]) ? sat_inc(oc_cnt_q[i]) : '0;
			trip[i] = live[i] && (ot[i] ||
				(oc[i] && oc_cnt_q[i] >= CW'(OC_CYCLES - 1)));
			// latched off until control goes low
			if (hold_q) begin
				latch_d[i] = 1'b0;
			end else if (trip[i]) begin
				latch_d[i] = 1'b1;
			end else if (!ctrl[i]) begin
				latch_d[i] = 1'b0;
			end else begin
				latch_d[i] = latch_q[i];
			end
			// low or floating input means off
			on_d[i] = ctrl[i] && !latch_d[i] && !hold_q;
			gnd_cond[i]  = !ctrl[i] && drain_low[i];
			open_cond[i] = live[i] && cur_low[i];
			// one filter counter for both checks
			if ((ctrl[i] != ctrl_prev_q[i]) || !(gnd_cond[i] || open_cond[i])) begin
				diag_cnt_d[i] = '0;
			end else begin
				diag_cnt_d[i] = sat_inc(diag_cnt_q[i]);
			end
			gnd_hit[i]  = gnd_cond[i] && (diag_cnt_q[i] == CW'(GND_CYCLES - 1));
			open_hit[i] = open_cond[i] && (diag_cnt_q[i] == CW'(OPEN_CYCLES - 1));
			// static open load waits for rise
			// sporadic open load stored on recovery
			ol_store[i] = pend_q[i] && (rise[i] || (live[i] && !cur_low[i]));
			if (hold_q || ol_store[i]) begin
				pend_d[i] = 1'b0;
			end else if (open_hit[i]) begin
				pend_d[i] = 1'b1;
			end else begin
				pend_d[i] = pend_q[i];
			end
			// overcurrent and overtemp share a code
			if (trip[i]) begin
				new_code[i] = qsd_pkg::CODE_OVER;
			end else if (gnd_hit[i]) begin
				new_code[i] = qsd_pkg::CODE_GND;
			end else if (ol_store[i]) begin
				new_code[i] = qsd_pkg::CODE_OPEN;
			end else begin
				new_code[i] = qsd_pkg::CODE_NONE;
			end
			// clear only what was copied out
			base_code[i] = (clear_evt && fail_q[i] == snap_q[i]) ? qsd_pkg::CODE_NONE
				: fail_q[i];
			// higher rank wins, set beats clear
			fail_d[i] = hold_q ? qsd_pkg::CODE_NONE : code_max(base_code[i], new_code[i]);
		end
		snap_d = cs_fall ? fail_q : snap_q;
	end

	// channel and store registers
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			ctrl_prev_q  <= '0;
			latch_q      <= '0;
			pend_q       <= '0;
			on_q         <= '0;
			oc_cnt_q     <= '0;
			diag_cnt_q   <= '0;
			fail_q       <= '0;
			snap_q       <= '0;
			hold_q       <= 1'b1;
			cs_prev_q    <= 1'b0;
			first_prev_q <= 1'b0;
		end else begin
			ctrl_prev_q  <= ctrl_prev_d;
			latch_q      <= latch_d;
			pend_q       <= pend_d;
			on_q         <= on_d;
			oc_cnt_q     <= oc_cnt_d;
			diag_cnt_q   <= diag_cnt_d;
			fail_q       <= fail_d;
			snap_q       <= snap_d;
			hold_q       <= hold_d;
			cs_prev_q    <= cs_n_s;
			first_prev_q <= first_s;
		end
	end

	// ==========================================================
	// outputs and serial link
	assign o_channel_on = on_q;
	// channel 0 in the low two bits
	assign lnk.snap     = snap_q;
	assign lnk.hold     = hold_q;

	qsd_spi_link u_link (
		.i_spi_clk       (i_spi_clk),
		.i_chip_select_n (i_chip_select_n),
		.i_sdi           (i_sdi),
		.o_sdo           (o_sdo),
		.o_sdo_oe        (o_sdo_oe),
		.lnk             (lnk)
	);

	// ==========================================================
	// assertions
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	int gnd_last;
	assign gnd_last = GND_CYCLES - 1;

	hold_off_a: assert property (hold_q |=> on_q == '0)
		else $error("channel on during hold");
	hold_clear_a: assert property (hold_q |=> fail_q == '0)
		else $error("fault store not cleared during hold");
	snap_copy_a: assert property (cs_fall |=> snap_q == $past(fail_q))
		else $error("snapshot not taken at frame start");

	for (genvar g = 0; g < NCH; g++) begin : g_chk
		ctrl_off_a: assert property (!ctrl[g] |=> !on_q[g])
			else $error("channel on without control");
		trip_off_a: assert property (on_q[g] && ot[g] && !hold_q
			|=> !on_q[g] && fail_q[g] == qsd_pkg::CODE_OVER)
			else $error("overtemp did not trip and record");
		latch_hold_a: assert property (latch_q[g] && ctrl[g] ##1 ctrl[g]
			|-> !on_q[g])
			else $error("tripped channel came back without toggle");
		over_keep_a: assert property (fail_q[g] == qsd_pkg::CODE_OVER && !clear_evt
			&& !hold_q |=> fail_q[g] == qsd_pkg::CODE_OVER)
			else $error("top fault overwritten");
		gnd_filter_a: assert property (fail_q[g] < qsd_pkg::CODE_GND
			##1 fail_q[g] == qsd_pkg::CODE_GND
			|-> $past(diag_cnt_q[g]) == CW'(gnd_last))
			else $error("ground short stored before filter time");
		open_store_a: assert property (fail_q[g] == qsd_pkg::CODE_NONE && !hold_q
			##1 fail_q[g] == qsd_pkg::CODE_OPEN
			|-> $past(pend_q[g]) && ($past(rise[g]) || $past(on_q[g])))
			else $error("open load stored without edge or recovery");
	end

	trip_cov: cover property (on_q[0] ##1 !on_q[0] && latch_q[0]);
	gnd_cov: cover property (gnd_hit[1]);
	frame_cov: cover property (cs_fall ##[1:40] clear_evt);

endmodule
`default_nettype wire

// ---- src/qsd_pkg.sv ----
// package: constants of the quad switch fault diagnostics
package qsd_pkg;

	// ==========================================================
	// channel and code layout
	localparam int          NCH        = 4;
	localparam int          CODE_W     = 2;
	localparam int          BYTE_W     = NCH * CODE_W;
	localparam logic [1:0]  CODE_NONE  = 2'h0;
	localparam logic [1:0]  CODE_OPEN  = 2'h1;
	localparam logic [1:0]  CODE_GND   = 2'h2;
	localparam logic [1:0]  CODE_OVER  = 2'h3;

	// ==========================================================
	// synchroniser vector layout
	localparam int          SYN_CTRL   = 0;
	localparam int          SYN_OC     = 4;
	localparam int          SYN_OT     = 8;
	localparam int          SYN_DRAIN  = 12;
	localparam int          SYN_CUR    = 16;
	localparam int          SYN_EXTRST = 20;
	localparam int          SYN_UV     = 21;
	localparam int          SYN_CS     = 22;
	localparam int          SYN_FIRST  = 23;
	localparam int          SYN_W      = 24;

	// ==========================================================
	// timing
	localparam int          CLK_PERIOD_NS        = 10;
	localparam int          OC_FILTER_TIME_NS    = 3000;
	localparam int          GND_FILTER_TIME_NS   = 140000;
	localparam int          OPEN_FILTER_TIME_NS  = 140000;
	localparam int          OC_FILTER_CYCLES     =
		(OC_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          GND_FILTER_CYCLES    =
		(GND_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          OPEN_FILTER_CYCLES   =
		(OPEN_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          CNT_W                = 16;

endpackage

// ---- src/qsd_link_if.sv ----
// interface: fault byte and frame status between core and serial link
`timescale 1ns/100ps
`default_nettype none
interface qsd_link_if;
	logic [qsd_pkg::BYTE_W-1:0] snap;
	logic                       hold;
	logic                       first_seen;

	modport core (
		output snap,
		output hold,
		input  first_seen
	);
	modport link (
		input  snap,
		input  hold,
		output first_seen
	);
endinterface
`default_nettype wire

// ---- src/qsd_spi_link.sv ----
// module: serial diagnostic shift register on the link clock
`timescale 1ns/100ps
`default_nettype none
module qsd_spi_link (
	input  wire logic         i_spi_clk,
	input  wire logic         i_chip_select_n,
	input  wire logic         i_sdi,
	output logic              o_sdo,
	output logic              o_sdo_oe,
	qsd_link_if.link          lnk
);

	logic [qsd_pkg::BYTE_W-1:0] shift_q;
	logic [qsd_pkg::BYTE_W-1:0] shift_d;
	logic                       first_q;
	logic                       sdi_q;

	// ==========================================================
	// shift path
	// first edge loads byte
	always_comb begin
		if (!first_q) begin
			shift_d = lnk.snap;
		end else begin
			shift_d = {shift_q[qsd_pkg::BYTE_W-2:0], sdi_q};
		end
	end

	always_ff @(posedge i_spi_clk or posedge i_chip_select_n) begin
		if (i_chip_select_n) begin
			first_q <= 1'b0;
			shift_q <= '0;
		end else begin
			first_q <= 1'b1;
			shift_q <= shift_d;
		end
	end

	always_ff @(negedge i_spi_clk or posedge i_chip_select_n) begin
		if (i_chip_select_n) begin
			sdi_q <= 1'b0;
		end else begin
			sdi_q <= i_sdi;
		end
	end

	// ==========================================================
	// pin drive
	// leading flag then data, float when deselected
	assign o_sdo          = first_q ? shift_q[qsd_pkg::BYTE_W-1] : (|lnk.snap);
	assign o_sdo_oe       = !i_chip_select_n && !lnk.hold;
	assign lnk.first_seen = first_q;

endmodule
`default_nettype wire

// ---- tb/qsd_mcu_model.sv ----
// partner: controller that reads the fault byte over the serial link
`timescale 1ns/100ps
`default_nettype none
module qsd_mcu_model (
	input  wire logic i_sdo,
	input  wire logic i_sdo_oe,
	output logic      o_spi_clk,
	output logic      o_chip_select_n,
	output logic      o_sdi
);
	// ==========================================================
	// idle: clock low, deselected, data pulled up
	initial begin
		o_spi_clk = 1'b0;
		o_chip_select_n = 1'b1;
		o_sdi = 1'b1;
	end

	// ==========================================================
	// one frame: flag, eight bits msb first, enable in and after frame
	task automatic read_frame(input int half, output logic f, output logic [7:0] b,
		output logic oe_in, output logic oe_out);
		o_chip_select_n = 1'b0;
		#100;
		// floating line with no pull: seen as the inverse of the last drive
		f = i_sdo_oe ? i_sdo : ~i_sdo;
		oe_in = i_sdo_oe;
		for (int i = 7; i >= 0; i--) begin
			o_spi_clk = 1'b1;
			#(half);
			o_spi_clk = 1'b0;
			o_sdi = ~o_sdi; // changing pattern in
			#(half);
			b[i] = i_sdo_oe ? i_sdo : ~i_sdo;
			oe_in = oe_in & i_sdo_oe;
		end
		#150;
		o_chip_select_n = 1'b1;
		o_sdi = 1'b1;
		#40;
		oe_out = i_sdo_oe;
	endtask
endmodule
`default_nettype wire

// ---- tb/test_quad_switch_fault_diagnostics.sv ----
// testbench: channel control, fault store and serial readout
`timescale 1ns/100ps
`default_nettype none
module test_quad_switch_fault_diagnostics;
	localparam int OC = 5;
	localparam int GND = 20;
	logic       i_clk;
	logic       i_reset_n;
	logic [3:0] ctrl, oc, ot, drn, cur, on;
	logic       ext_n, uv, spi_clk, cs_n, sdi, sdo, sdo_oe;
	logic [7:0] rows [5] = '{8'h00, 8'h55, 8'haa, 8'hff, 8'h00};
	logic       f, oi, oo;
	logic [7:0] b;
	int         fails, n_compared;

	// ==========================================================
	// design and partner
	qsd_top #(.OC_CYCLES(OC), .GND_CYCLES(GND), .OPEN_CYCLES(20)) dut_u (
		.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ctrl_on(ctrl),
		.i_overcurrent(oc), .i_overtemp(ot), .i_drain_low(drn),
		.i_current_low(cur), .i_external_reset_n(ext_n), .i_undervoltage(uv),
		.i_spi_clk(spi_clk), .i_chip_select_n(cs_n), .i_sdi(sdi),
		.o_channel_on(on), .o_sdo(sdo), .o_sdo_oe(sdo_oe));
	qsd_mcu_model mcu_u (.i_sdo(sdo), .i_sdo_oe(sdo_oe), .o_spi_clk(spi_clk),
		.o_chip_select_n(cs_n), .o_sdi(sdi));

	// ==========================================================
	// clock, helpers
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cyc(int n);
		repeat (n) @(posedge i_clk);
	endtask

	task automatic frame(logic [7:0] exp, int half);
		mcu_u.read_frame(half, f, b, oi, oo);
		check("fault byte", b, exp);
		check("flag", {7'h0, f}, {7'h0, |exp});
		check("oe in frame", {7'h0, oi}, 8'h01);
		check("oe idle", {7'h0, oo}, 8'h00);
		cyc(10);
	endtask

	// second read, slow clock, sees the store cleared
	task automatic frame2(logic [7:0] exp);
		frame(exp, 6);
		frame(8'h00, 50);
	endtask

	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ==========================================================
	// hang guard
	initial begin
		#400000;
		fails++;
		end_of_test();
	end

	// ==========================================================
	// main sequence
	initial begin
		i_reset_n = 1'b0;
		{ctrl, oc, ot, drn, cur} = '0;
		ext_n = 1'b1;
		uv = 1'b0;
		cyc(3);
		i_reset_n <= 1'b1;
		cyc(6);
		// rows: control pattern beside the expected drive
		foreach (rows[k]) begin
			ctrl <= rows[k][7:4];
			cyc(4);
			check("channel on", {4'h0, on}, {4'h0, rows[k][3:0]});
		end
		$display("test table done");
		ctrl <= 4'h1;
		ot <= 4'h2;
		cyc(8);
		check("ot ignored off", {4'h0, on}, 8'h01);
		ot <= 4'h1;
		cyc(5);
		check("ot trip", {4'h0, on}, 8'h00);
		ot <= 4'h0;
		cyc(5);
		check("stays off", {4'h0, on}, 8'h00);
		ctrl <= 4'h0;
		cyc(4);
		ctrl <= 4'h1;
		cyc(4);
		check("re-enabled", {4'h0, on}, 8'h01);
		frame2(8'h03);
		$display("test overtemp done");
		// overcurrent one cycle short, then long enough
		ctrl <= 4'h2;
		cyc(4);
		oc <= 4'h2;
		cyc(OC - 1);
		oc <= 4'h0;
		cyc(6);
		check("oc short", {4'h0, on}, 8'h02);
		oc <= 4'h2;
		cyc(OC + 4);
		oc <= 4'h0;
		check("oc trip", {4'h0, on}, 8'h00);
		frame2(8'h0c);
		$display("test overcurrent done");
		// ground spike, ground short, then outranked
		ctrl <= 4'h0;
		drn <= 4'h4;
		cyc(GND / 2);
		drn <= 4'h0;
		cyc(4);
		frame(8'h00, 6);
		drn <= 4'h4;
		cyc(GND + 6);
		drn <= 4'h0;
		frame2(8'h20);
		drn <= 4'h4;
		cyc(GND + 6);
		drn <= 4'h0;
		ctrl <= 4'h4;
		cyc(4);
		ot <= 4'h4;
		cyc(5);
		ot <= 4'h0;
		ctrl <= 4'h0;
		cyc(4);
		frame2(8'h30);
		$display("test ground short done");
		ctrl <= 4'h8;
		cur <= 4'h8;
		cyc(30);
		frame(8'h00, 6);
		ctrl <= 4'h0;
		cyc(4);
		ctrl <= 4'h8;
		cyc(4);
		cur <= 4'h0;
		frame2(8'h40);
		cur <= 4'h8;
		cyc(30);
		cur <= 4'h0;
		cyc(4);
		frame2(8'h40);
		$display("test open load done");
		for (int k = 0; k < 2; k++) begin
			ctrl <= 4'h0;
			drn <= 4'h1;
			cyc(GND + 6);
			drn <= 4'h0;
			ctrl <= 4'hf;
			cyc(4);
			if (k == 0)
				ext_n <= 1'b0;
			else
				uv <= 1'b1;
			cyc(6);
			check("held off", {4'h0, on}, 8'h00);
			mcu_u.read_frame(6, f, b, oi, oo);
			check("oe in hold", {7'h0, oi}, 8'h00);
			cyc(1);
			ext_n <= 1'b1;
			uv <= 1'b0;
			cyc(10);
			frame2(8'h00);
		end
		$display("test reset done");
		end_of_test();
	end
endmodule
`default_nettype wire
